//--- rtl/irq_arb_if.sv
// Request and answer signals between the controller and its arbiter.
interface irq_arb_if;
	logic [irq_pkg::NSRC-1:0] pend;
	logic [irq_pkg::NSRC-1:0] prio;
	logic [irq_pkg::NSRC-1:0] peri;
	logic                     ple;
	logic                     g_hi;
	logic                     g_lo;
	logic                     in_hi;
	logic                     idle;
	logic                     take_hi;
	logic                     take_lo;
	modport ctl (output pend, prio, peri, ple, g_hi, g_lo, in_hi, idle,
		input take_hi, take_lo);
	modport arb (input pend, prio, peri, ple, g_hi, g_lo, in_hi, idle,
		output take_hi, take_lo);
endinterface : irq_arb_if

//--- rtl/irq_arbiter.sv
// Priority and mode selection between pending interrupt sources.
module irq_arbiter (
	irq_arb_if.arb a
);
	wire [irq_pkg::NSRC-1:0] hi_set;
	wire [irq_pkg::NSRC-1:0] lo_set;
	wire [irq_pkg::NSRC-1:0] cmp_set;
	wire                     any_hi;
	wire                     any_lo;
	wire                     any_cmp;

	assign hi_set  = a.pend & a.prio;
	assign lo_set  = a.pend & ~a.prio;
	assign cmp_set = a.pend & (~a.peri | {irq_pkg::NSRC{a.g_lo}}); // R8
	// A high request may preempt a low routine, never another high one.
	assign any_hi  = (|hi_set) & a.g_hi & ~a.in_hi; // R2 R5 R6
	assign any_lo  = (|lo_set) & a.g_lo & ~a.in_hi; // R5 R6 R11
	assign any_cmp = (|cmp_set) & a.g_hi & ~a.in_hi; // R7 R8
	assign a.take_hi = a.idle & (a.ple ? any_hi : any_cmp); // R4 R7
	assign a.take_lo = a.idle & a.ple & any_lo & ~any_hi; // R18
endmodule : irq_arbiter

//--- rtl/irq_ctrl.sv
// Two-level interrupt controller with register port and core vectoring.
// Behaviour
// R1: With levels on, high requests vector to 0008h and low ones to 0018h.
// R2: A pending enabled high request preempts a running low routine.
// R3: Each source has a flag, an individual enable and a priority bit.
// R4: Two-level priority works only while priority_levels_enable is set.
// R5: In two-level mode bit 7 gates high sources and bit 6 low sources.
// R6: Flag, enable and matching global enable together cause the vector.
// R7: With priority_levels_enable clear the priority bits have no effect.
// R8: In compatibility mode bit 6 gates peripherals, bit 7 gates everything.
// R9: In compatibility mode every interrupt vectors to 0008h.
// R10: Taking an interrupt clears the global enable of that level.
// R11: No low request is served while a high routine runs.
// R12: Entry pushes the return address, then loads the vector.
// R13: Software clears causing flags before enabling interrupts again.
// R14: Return from interrupt sets the global enable of the level left.
// R15: Pin events reach the vector in three to four cycles.
// R16: Flags set on their event regardless of any enable.
// R17: Software avoids file-to-file moves on control registers while enabled.
// R18: When high and low are both pending, high is served first.
//
// The register addresses and the plain strobed port are this design's own decisions.
module irq_ctrl (
	// Clock and reset.
	input  wire logic                              i_clk_sys,
	input  wire logic                              i_rst,
	// Register port.
	input  wire logic [irq_pkg::AW-1:0]            i_addr,
	input  wire logic [irq_pkg::DW-1:0]            i_wdata,
	input  wire logic                              i_wr,
	input  wire logic                              i_rd,
	output logic      [irq_pkg::DW-1:0]            o_rdata_q,
	// Interrupt sources.
	input  wire logic [irq_pkg::NPIN-1:0]          i_pin,
	input  wire logic [irq_pkg::NSRC-irq_pkg::NPIN-1:0] i_src_evt,
	// Core side.
	input  wire logic                              i_ret,
	output logic                                   o_push_q,
	output logic                                   o_load_q,
	output logic      [irq_pkg::PCW-1:0]           o_vector_q,
	output logic                                   o_in_high_q,
	output logic                                   o_in_low_q,
	// Interrupt line.
	output logic                                   o_irq_q
);
	irq_arb_if arb_bus ();

	logic [irq_pkg::NPIN-1:0]  pin_rise;
	logic [irq_pkg::NSRC-1:0]  ev;
	logic                      ghi_q;
	logic                      glo_q;
	logic                      ple_q;
	logic [irq_pkg::NSRC-1:0]  flag_q;
	logic [irq_pkg::NSRC-1:0]  en_q;
	logic [irq_pkg::NSRC-1:0]  prio_q;
	logic [irq_pkg::NSRC-1:0]  peri_q;
	logic [irq_pkg::NEV-1:0]   est_q;
	logic [irq_pkg::NEV-1:0]   een_q;
	logic                      in_hi_q;
	logic                      in_lo_q;
	irq_pkg::entry_state_t     st_q;
	irq_pkg::entry_state_t     st_d;
	logic [irq_pkg::PCW-1:0]   vec_q;

	irq_pin_sync u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_pin     (i_pin),
		.o_rise    (pin_rise)
	);

	irq_arbiter u_arb (
		.a (arb_bus)
	);

	// Pin edges sit in the low sources, internal pulses above them.
	assign ev = {i_src_evt, pin_rise};

	// Register decode.
	wire wr_ctrl = i_wr & (i_addr == irq_pkg::A_CTRL);
	wire wr_rctl = i_wr & (i_addr == irq_pkg::A_RCTL);
	wire wr_flag = i_wr & (i_addr == irq_pkg::A_FLAG);
	wire wr_en   = i_wr & (i_addr == irq_pkg::A_EN);
	wire wr_prio = i_wr & (i_addr == irq_pkg::A_PRIO);
	wire wr_peri = i_wr & (i_addr == irq_pkg::A_PERI);
	wire wr_eclr = i_wr & (i_addr == irq_pkg::A_ECLR);
	wire wr_een  = i_wr & (i_addr == irq_pkg::A_EEN);

	// Arbiter requests.
	wire idle = (st_q == irq_pkg::ST_IDLE);
	// An event counts in the cycle it arrives, before the flag holds it.
	assign arb_bus.pend  = (flag_q | ev) & en_q; // R3 R6
	assign arb_bus.prio  = prio_q; // R3
	assign arb_bus.peri  = peri_q;
	assign arb_bus.ple   = ple_q; // R4
	assign arb_bus.g_hi  = ghi_q;
	assign arb_bus.g_lo  = glo_q;
	assign arb_bus.in_hi = in_hi_q;
	assign arb_bus.idle  = idle;

	wire go_hi = arb_bus.take_hi;
	wire go_lo = arb_bus.take_lo;
	wire go    = go_hi | go_lo;

	// Return leaves the high level first, else the low level.
	wire ret_hi = i_ret & (in_hi_q | ~in_lo_q); // R14
	wire ret_lo = i_ret & ~in_hi_q & in_lo_q; // R14

	// Global enables: software write, then return sets, then entry clears.
	wire ghi_w = wr_ctrl ? i_wdata[irq_pkg::B_HIGH] : ghi_q;
	wire glo_w = wr_ctrl ? i_wdata[irq_pkg::B_LOW] : glo_q;
	wire ghi_d = (ghi_w | ret_hi) & ~go_hi; // R10 R14
	wire glo_d = (glo_w | ret_lo) & ~go_lo; // R10 R14

	wire in_hi_d = go_hi | (in_hi_q & ~ret_hi);
	wire in_lo_d = go_lo | (in_lo_q & ~ret_lo);

	// Flags: a hardware set wins over a software clear.
	wire [irq_pkg::NSRC-1:0] flag_w = wr_flag ? i_wdata : flag_q;
	wire [irq_pkg::NSRC-1:0] flag_d = flag_w | ev; // R16

	// High vector is used in both modes; low exists only with levels on.
	wire [irq_pkg::PCW-1:0] vec_d = go_hi ? irq_pkg::VEC_HIGH :
		go_lo ? irq_pkg::VEC_LOW : vec_q; // R1 R9

	// Event status for the interrupt line.
	wire [irq_pkg::NEV-1:0] ev_set = {i_ret, go_lo, go_hi};
	wire [irq_pkg::NEV-1:0] eclr   = wr_eclr ?
		i_wdata[irq_pkg::NEV-1:0] : {irq_pkg::NEV{1'b0}};
	wire [irq_pkg::NEV-1:0] est_d  = (est_q & ~eclr) | ev_set;
	wire [irq_pkg::NEV-1:0] een_d  = wr_een ?
		i_wdata[irq_pkg::NEV-1:0] : een_q;
	wire                    irq_d  = |(est_d & een_d);

	// Readback.
	wire [irq_pkg::DW-1:0] ctrl_rd = {ghi_q, glo_q, 6'h00};
	wire [irq_pkg::DW-1:0] rctl_rd = {ple_q, 7'h00};
	wire [irq_pkg::DW-1:0] core_rd = {5'h00, ~idle, in_hi_q, in_lo_q};
	wire [irq_pkg::DW-1:0] est_rd  = {5'h00, est_q};
	wire [irq_pkg::DW-1:0] een_rd  = {5'h00, een_q};
	wire [irq_pkg::DW-1:0] rd_mux =
		(i_addr == irq_pkg::A_CTRL) ? ctrl_rd :
		(i_addr == irq_pkg::A_RCTL) ? rctl_rd :
		(i_addr == irq_pkg::A_FLAG) ? flag_q :
		(i_addr == irq_pkg::A_EN)   ? en_q :
		(i_addr == irq_pkg::A_PRIO) ? prio_q :
		(i_addr == irq_pkg::A_PERI) ? peri_q :
		(i_addr == irq_pkg::A_CORE) ? core_rd :
		(i_addr == irq_pkg::A_EST)  ? est_rd :
		(i_addr == irq_pkg::A_EEN)  ? een_rd :
		irq_pkg::RST_REG;

	// Entry sequence: push the return address, then load the vector.
	always_comb begin
		case (st_q)
			irq_pkg::ST_IDLE: begin
				st_d = go ? irq_pkg::ST_PUSH : irq_pkg::ST_IDLE; // R12
			end
			irq_pkg::ST_PUSH: begin
				st_d = irq_pkg::ST_LOAD; // R12
			end
			irq_pkg::ST_LOAD: begin
				st_d = irq_pkg::ST_IDLE;
			end
			default: begin
				st_d = irq_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ghi_q <= 1'b0;
			glo_q <= 1'b0;
			ple_q <= 1'b0; // R7
			flag_q <= irq_pkg::RST_REG;
			en_q <= irq_pkg::RST_REG;
			prio_q <= irq_pkg::RST_REG;
			peri_q <= irq_pkg::RST_REG;
		end else begin
			ghi_q <= ghi_d;
			glo_q <= glo_d;
			ple_q <= wr_rctl ? i_wdata[irq_pkg::B_PLE] : ple_q; // R4
			flag_q <= flag_d;
			en_q <= wr_en ? i_wdata : en_q;
			prio_q <= wr_prio ? i_wdata : prio_q;
			peri_q <= wr_peri ? i_wdata : peri_q;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st_q <= irq_pkg::ST_IDLE;
			in_hi_q <= 1'b0;
			in_lo_q <= 1'b0;
			vec_q <= irq_pkg::VEC_HIGH;
			est_q <= {irq_pkg::NEV{1'b0}};
			een_q <= {irq_pkg::NEV{1'b0}};
		end else begin
			st_q <= st_d;
			in_hi_q <= in_hi_d;
			in_lo_q <= in_lo_d;
			vec_q <= vec_d;
			est_q <= est_d;
			een_q <= een_d;
		end
	end

	// Output flops.
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_rdata_q <= irq_pkg::RST_REG;
			o_push_q <= 1'b0;
			o_load_q <= 1'b0;
			o_vector_q <= irq_pkg::VEC_HIGH;
			o_in_high_q <= 1'b0;
			o_in_low_q <= 1'b0;
			o_irq_q <= 1'b0;
		end else begin
			o_rdata_q <= i_rd ? rd_mux : irq_pkg::RST_REG;
			o_push_q <= (st_d == irq_pkg::ST_PUSH); // R12
			o_load_q <= (st_d == irq_pkg::ST_LOAD); // R12
			o_vector_q <= vec_d;
			o_in_high_q <= in_hi_d;
			o_in_low_q <= in_lo_d;
			o_irq_q <= irq_d;
		end
	end

	// Checks.
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	sequence s_push_then_load;
		o_push_q && !o_load_q ##1 o_load_q && !o_push_q;
	endsequence

	sequence s_vec_held(logic [irq_pkg::PCW-1:0] v);
		(o_vector_q == v) [*2];
	endsequence

	property p_entry(logic take, logic [irq_pkg::PCW-1:0] v);
		take |=> s_push_then_load and s_vec_held(v);
	endproperty

	a_entry_push_load: assert property (go |=> s_push_then_load) // R12
		else $error("entry did not push then load");

	a_vector_high: assert property (p_entry(go_hi, irq_pkg::VEC_HIGH)) // R1 R9
		else $error("high entry vector wrong");

	a_vector_low: assert property (p_entry(go_lo, irq_pkg::VEC_LOW)) // R1
		else $error("low entry vector wrong");

	a_clear_high_gate: assert property (go_hi |=> !ghi_q && o_in_high_q) // R10
		else $error("high entry left its enable set");

	a_clear_low_gate: assert property (go_lo |=> !glo_q && o_in_low_q) // R10
		else $error("low entry left its enable set");

	a_low_blocked_hi: assert property (in_hi_q |-> !go_lo) // R11
		else $error("low taken during high routine");

	a_high_wins: assert property ((|(arb_bus.pend & prio_q) && ghi_q && ple_q
		&& idle && !in_hi_q) |-> go_hi && !go_lo) // R18 R2
		else $error("high request not preferred");

	a_compat_no_low: assert property (!ple_q |-> !go_lo) // R7 R9
		else $error("low vector used in compatibility mode");

	a_gate_needed: assert property (go_hi |-> ghi_q && |arb_bus.pend
		&& (!ple_q || |(arb_bus.pend & prio_q))) // R5 R6 R8
		else $error("entry without enables");

	a_flag_sets: assert property (|ev |=> (flag_q & $past(ev)) == $past(ev)) // R16
		else $error("event flag not set");

	a_return_sets: assert property ((i_ret && in_hi_q && !ghi_q)
		|=> ghi_q && !in_hi_q) // R14
		else $error("return did not restore enable");

	a_pin_latency: assert property ((|(pin_rise & en_q[irq_pkg::NPIN-1:0] // R15
		& (~peri_q[irq_pkg::NPIN-1:0] | {irq_pkg::NPIN{glo_q}}))
		&& ghi_q && !ple_q && idle && !in_hi_q) |=> o_push_q ##1 o_load_q)
		else $error("pin event latency exceeded");

	// Gating, return, register write and pulse shape checks.
	a_low_gate_needed: assert property (go_lo |-> glo_q && ple_q // R5 R6
		&& |(arb_bus.pend & ~prio_q))
		else $error("low entry without enables");

	a_compat_peri_gate: assert property ((go_hi && !ple_q) // R8
		|-> |(arb_bus.pend & (~peri_q | {irq_pkg::NSRC{glo_q}})))
		else $error("peripheral entry without its enable");

	a_busy_no_entry: assert property (!idle // R12
		|-> !go)
		else $error("entry started during entry");

	a_high_preempts: assert property ((in_lo_q && !in_hi_q && idle && ple_q // R2
		&& ghi_q && |(arb_bus.pend & prio_q)) |-> go_hi)
		else $error("high request did not preempt low routine");

	a_pend_needed: assert property (!(|arb_bus.pend) // R6
		|-> !go)
		else $error("entry without a pending source");

	a_return_low: assert property ((i_ret && in_lo_q && !in_hi_q && !go_lo) // R14
		|=> glo_q && !o_in_low_q)
		else $error("return did not restore low enable");

	a_vector_stands: assert property (!go // R1 R12
		|=> $stable(o_vector_q))
		else $error("vector changed without entry");

	a_level_write: assert property (wr_rctl // R4
		|=> ple_q == $past(i_wdata[irq_pkg::B_PLE]))
		else $error("level mode write lost");

	a_enable_write: assert property (wr_en // R3
		|=> en_q == $past(i_wdata))
		else $error("enable write lost");

	a_prio_write: assert property (wr_prio // R3
		|=> prio_q == $past(i_wdata))
		else $error("priority write lost");

	a_peri_write: assert property (wr_peri // R8
		|=> peri_q == $past(i_wdata))
		else $error("peripheral mask write lost");

	a_entry_status: assert property (go_hi
		|=> est_q[irq_pkg::EV_HI])
		else $error("high entry status not set");

	a_flag_held: assert property ((!(|ev) && !wr_flag) // R16
		|=> $stable(flag_q))
		else $error("flag changed without event or write");

	a_pin_edge_once: assert property (|pin_rise // R15
		|=> (pin_rise & $past(pin_rise)) == {irq_pkg::NPIN{1'b0}})
		else $error("pin edge reported twice");

	a_read_idle: assert property (!i_rd
		|=> o_rdata_q == irq_pkg::RST_REG)
		else $error("read data without read strobe");

	a_push_once: assert property (o_push_q // R12
		|=> !o_push_q)
		else $error("push longer than one cycle");
endmodule : irq_ctrl

//--- rtl/irq_pin_sync.sv
// Three-stage synchroniser and rising-edge detector for external pins.
module irq_pin_sync (
	// Clock and reset.
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_rst,
	// Pins and edges.
	input  wire logic [irq_pkg::NPIN-1:0] i_pin,
	output logic      [irq_pkg::NPIN-1:0] o_rise
);
	genvar g;
	generate
		for (g = 0; g < irq_pkg::NPIN; g++) begin : g_pin
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic lvl_q;
			always_ff @(posedge i_clk_sys) begin
				if (i_rst) begin
					s1_q  <= 1'b0;
					s2_q  <= 1'b0;
					s3_q  <= 1'b0;
					lvl_q <= 1'b0;
				end else begin
					s1_q <= i_pin[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						lvl_q <= s3_q;
					end
				end
			end
			// A change counts once the second and third stages agree.
			assign o_rise[g] = (s2_q == s3_q) & s3_q & ~lvl_q; // R15
		end
	endgenerate
endmodule : irq_pin_sync

//--- rtl/irq_pkg.sv
// Shared constants, register map and state encoding of the interrupt controller.
package irq_pkg;
	localparam int NSRC = 8;
	localparam int NPIN = 3;
	localparam int DW   = 8;
	localparam int AW   = 4;
	localparam int PCW  = 16;
	localparam int NEV  = 3;

	localparam logic [AW-1:0] A_CTRL = 4'h0;
	localparam logic [AW-1:0] A_RCTL = 4'h1;
	localparam logic [AW-1:0] A_FLAG = 4'h2;
	localparam logic [AW-1:0] A_EN   = 4'h3;
	localparam logic [AW-1:0] A_PRIO = 4'h4;
	localparam logic [AW-1:0] A_PERI = 4'h5;
	localparam logic [AW-1:0] A_CORE = 4'h6;
	localparam logic [AW-1:0] A_EST  = 4'h7;
	localparam logic [AW-1:0] A_ECLR = 4'h8;
	localparam logic [AW-1:0] A_EEN  = 4'h9;

	localparam int B_HIGH = 7;
	localparam int B_LOW  = 6;
	localparam int B_PLE  = 7;
	localparam int B_INLO = 0;
	localparam int B_INHI = 1;
	localparam int B_BUSY = 2;
	localparam int EV_HI  = 0;
	localparam int EV_LO  = 1;
	localparam int EV_RET = 2;

	localparam logic [PCW-1:0] VEC_HIGH = 16'h0008;
	localparam logic [PCW-1:0] VEC_LOW  = 16'h0018;
	localparam logic [DW-1:0]  RST_REG  = 8'h00;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PUSH = 2'b01,
		ST_LOAD = 2'b10
	} entry_state_t;
endpackage : irq_pkg

//--- verification/irq_core_model.sv
// Behavioural core that follows vector requests and executes returns.
module irq_core_model (
	// Clock and reset.
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_rst,
	// Controller side.
	input  wire logic                    i_push,
	input  wire logic                    i_load,
	input  wire logic [irq_pkg::PCW-1:0] i_vector,
	output logic                         o_ret,
	// Bench side.
	input  wire logic                    i_do_ret,
	output int                           o_entries,
	output int                           o_order_errs,
	output logic      [irq_pkg::PCW-1:0] o_pc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pushed_q;
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_ret <= 1'b0;
			pushed_q <= 1'b0;
			o_entries <= 0;
			o_order_errs <= 0;
			o_pc <= 16'h0000;
		end else begin
			o_ret <= i_do_ret;
			pushed_q <= i_push;
			// A load must come exactly one cycle after its push.
			if (pushed_q !== i_load) o_order_errs <= o_order_errs + 1;
			if (i_load) begin
				o_entries <= o_entries + 1;
				o_pc <= i_vector;
			end
		end
	end
endmodule : irq_core_model

//--- verification/two_level_interrupt_controller_tb.sv
// Self-checking bench of the interrupt controller with a core model.
module two_level_interrupt_controller_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd_s = 1'b0;
	logic [7:0]  rdata;
	logic [2:0]  pin = 3'h0;
	logic [4:0]  evt_s = 5'h00;
	logic        ret;
	logic        do_ret = 1'b0;
	logic        push;
	logic        load;
	logic [15:0] vec;
	logic        in_hi;
	logic        in_lo;
	logic        irq;
	logic [15:0] pc;
	int          entries;
	int          order_errs;
	int          num_errors = 0;
	int          n_checks = 0;
	integer      seed = 32'h42a80077;

	irq_ctrl i_irq_ctrl (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd_s), .o_rdata_q(rdata), .i_pin(pin), .i_src_evt(evt_s),
		.i_ret(ret), .o_push_q(push), .o_load_q(load), .o_vector_q(vec),
		.o_in_high_q(in_hi), .o_in_low_q(in_lo), .o_irq_q(irq));
	irq_core_model i_irq_core_model (.i_clk_sys(clk), .i_rst(rst), .i_push(push),
		.i_load(load), .i_vector(vec), .o_ret(ret), .i_do_ret(do_ret),
		.o_entries(entries), .o_order_errs(order_errs), .o_pc(pc));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		check("rdata", {8'h00, rdata}, {8'h00, exp});
	endtask : rreg

	task automatic pulse(input logic [4:0] m);
		@(posedge clk);
		evt_s <= m;
		@(posedge clk);
		evt_s <= 5'h00;
	endtask : pulse

	task automatic do_return();
		@(posedge clk);
		do_ret <= 1'b1;
		@(posedge clk);
		do_ret <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : do_return

	task automatic wait_entry(input int n, input logic [15:0] exp_pc);
		int k;
		for (k = 0; k < 20 && entries < n; k++) begin
			@(posedge clk);
			#1;
		end
		check("entries", 16'(entries), 16'(n));
		check("vector", pc, exp_pc);
	endtask : wait_entry

	function automatic logic [15:0] exp_vec(input logic ple, input logic pr);
		return (ple && !pr) ? irq_pkg::VEC_LOW : irq_pkg::VEC_HIGH;
	endfunction : exp_vec

	// Fires one source behind the wrong gate, then opens the right one.
	task automatic take(input int s, input logic ple, input logic pr);
		logic [7:0] b;
		logic [7:0] good;
		int         n;
		b = 8'h01 << s;
		good = ple ? (pr ? 8'h80 : 8'h40) : 8'hC0;
		n = entries;
		wreg(irq_pkg::A_FLAG, 8'h00);
		wreg(irq_pkg::A_RCTL, {ple, 7'h00});
		wreg(irq_pkg::A_PRIO, pr ? b : 8'h00);
		wreg(irq_pkg::A_PERI, b);
		wreg(irq_pkg::A_EN, b);
		wreg(irq_pkg::A_CTRL, ple ? (pr ? 8'h40 : 8'h80) : 8'h80);
		pulse(b[7:3]);
		repeat (6) @(posedge clk);
		check("gated", 16'(entries), 16'(n));
		rreg(irq_pkg::A_FLAG, b);
		wreg(irq_pkg::A_CTRL, good);
		wait_entry(n + 1, exp_vec(ple, pr));
		rreg(irq_pkg::A_CTRL, ple ? 8'h00 : 8'h40);
		wreg(irq_pkg::A_FLAG, 8'h00);
		do_return();
		rreg(irq_pkg::A_CTRL, good);
	endtask : take

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end

	initial begin
		int i;
		int cnt;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 16; i++) rreg(4'(i), irq_pkg::RST_REG);
		wreg(irq_pkg::A_CORE, 8'hFF);
		rreg(irq_pkg::A_CORE, 8'h00);
		take(7, 1'b1, 1'b0);
		take(3, 1'b0, 1'b1);
		repeat (8) take(3 + int'($unsigned($random(seed)) % 5),
			1'($random(seed)), 1'($random(seed)));
		// Simultaneous high and low, then preemption of a low routine.
		wreg(irq_pkg::A_RCTL, 8'h80);
		wreg(irq_pkg::A_PRIO, 8'h20);
		wreg(irq_pkg::A_EN, 8'h38);
		wreg(irq_pkg::A_CTRL, 8'hC0);
		cnt = entries;
		pulse(5'h05);
		wait_entry(cnt + 1, irq_pkg::VEC_HIGH);
		repeat (6) @(posedge clk);
		check("blocked", 16'(entries), 16'(cnt + 1));
		wreg(irq_pkg::A_FLAG, 8'h08);
		do_return();
		wait_entry(cnt + 2, irq_pkg::VEC_LOW);
		wreg(irq_pkg::A_CTRL, 8'h80);
		pulse(5'h04);
		wait_entry(cnt + 3, irq_pkg::VEC_HIGH);
		check("nest", {14'h0000, in_hi, in_lo}, 16'h0003);
		wreg(irq_pkg::A_FLAG, 8'h00);
		do_return();
		do_return();
		// Pin latency and the event interrupt line.
		wreg(irq_pkg::A_RCTL, 8'h00);
		wreg(irq_pkg::A_EN, 8'h01);
		wreg(irq_pkg::A_ECLR, 8'h07);
		wreg(irq_pkg::A_CTRL, 8'h80);
		@(posedge clk);
		pin <= 3'h1;
		for (cnt = 0; cnt < 10 && push !== 1'b1; cnt++) begin
			@(posedge clk);
			#1;
		end
		check("latency", {15'h0000, cnt >= 3 && cnt <= 5}, 16'h0001);
		repeat (2) @(posedge clk);
		rreg(irq_pkg::A_CORE, 8'h02);
		rreg(irq_pkg::A_EST, 8'h01);
		check("irq_masked", {15'h0000, irq}, 16'h0000);
		wreg(irq_pkg::A_EEN, 8'h01);
		#1;
		check("irq_on", {15'h0000, irq}, 16'h0001);
		wreg(irq_pkg::A_ECLR, 8'h01);
		#1;
		check("irq_clr", {15'h0000, irq}, 16'h0000);
		wreg(irq_pkg::A_FLAG, 8'h00);
		pin <= 3'h0;
		do_return();
		check("order", 16'(order_errs), 16'h0000);
		report_and_stop();
	end
endmodule : two_level_interrupt_controller_tb
